// File: fanout_pkg.sv
// Purpose: Shared constants, state types and carriers of the clock fan-out block
// Assumes: System clock of 125 MHz; the loop runs as a scaled digital model
// Notes:   Reference is prescaled by 16 before it crosses into the system clock
package fanout_pkg;

  // System clock rate
  localparam int CLK_MHZ = 125;

  // Settling interval after any disturbance of the loop
  localparam int STAB_US  = 50;
  localparam int STAB_CYC = STAB_US * CLK_MHZ;
  localparam int STAB_W   = 16;

  // Reference is declared missing after this long without an edge
  localparam int             REF_LOSS_NS  = 2048;
  localparam int             REF_LOSS_CYC = (REF_LOSS_NS * CLK_MHZ) / 1000;
  localparam int             GAP_W        = 9;
  localparam logic [GAP_W-1:0] GAP_MAX    = GAP_W'(REF_LOSS_CYC);

  // Reference prescaler and model scale of the oscillator
  localparam int             PRE_W     = 4;
  localparam int             MODEL_DIV = 2 ** PRE_W;
  localparam logic [PRE_W-1:0] PRE_ONE = 4'h1;

  // Oscillator range and the matching phase increments
  localparam int               VCO_MIN_MHZ = 100;
  localparam int               VCO_MAX_MHZ = 200;
  localparam int               ACC_W       = 16;
  localparam logic [ACC_W-1:0] INC_MIN     = ACC_W'((VCO_MIN_MHZ * (2 ** ACC_W)) / (MODEL_DIV * CLK_MHZ));
  localparam logic [ACC_W-1:0] INC_MAX     = ACC_W'((VCO_MAX_MHZ * (2 ** ACC_W)) / (MODEL_DIV * CLK_MHZ));
  localparam logic [ACC_W-1:0] INC_RST     = ACC_W'((int'(INC_MIN) + int'(INC_MAX)) / 2);
  localparam logic [ACC_W-1:0] INC_STEP    = 16'h0004;

  // Bit order of the synchronised pin carrier, and pin reset levels
  localparam int         PIN_N   = 5;
  localparam logic [4:0] PIN_RST = 5'h04;

  typedef logic [2:0] bank_clk_type;

  typedef struct packed {
    logic ref_tog;
    logic fb;
    logic oe_n;
    logic sel;
    logic test;
  } pin_lvl_type;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic stable;
  } sync_state_type;

  typedef struct packed {
    logic [PRE_W-1:0] cnt;
  } pre_state_type;

  typedef struct packed {
    logic [ACC_W-1:0]  acc;
    logic [ACC_W-1:0]  inc;
    logic [1:0]        div;
    logic              ref_lead;
    logic              fb_lead;
    logic              ref_prev;
    logic              fb_prev;
    logic [GAP_W-1:0]  gap;
    logic              ref_ok;
    logic [STAB_W-1:0] stab;
    logic              locked;
    logic              sel_prev;
    logic              oe_prev;
    logic              test_prev;
    bank_clk_type      bank1;
    bank_clk_type      bank2;
    logic              drive_n;
  } core_state_type;

  localparam core_state_type CORE_RST = '{inc: INC_RST, drive_n: 1'b1, oe_prev: 1'b1, default: '0};

endpackage

// File: ref_prescale.sv
// Purpose: Divide the reference clock by 16 in its own domain
// Assumes: Reference toggles freely; reset is asynchronous
// Notes:   The slow square wave is the only thing crossing to the system clock
`timescale 1ns/1ns
module ref_prescale (
  input  wire logic reference_clock_in_i,
  input  wire logic nrst_i,
  output logic      ref_slow_o
);
  import fanout_pkg::*;

  pre_state_type st_r;
  pre_state_type st_nxt;

  // Free-running counter on every rising reference edge
  always_comb begin
    st_nxt     = st_r;
    st_nxt.cnt = st_r.cnt + PRE_ONE;
  end

  always_ff @(posedge reference_clock_in_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Top bit is a 50% square at one sixteenth of the reference
  assign ref_slow_o = st_r.cnt[PRE_W-1];

endmodule

// File: pin_sync.sv
// Purpose: Three-stage synchroniser for one asynchronous pin
// Assumes: Pin may change at any time relative to clk_i
// Notes:   A change is taken once the second and third stages agree
`timescale 1ns/1ns
module pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic pin_i,
  output logic      level_o
);
  import fanout_pkg::*;

  sync_state_type st_r;
  sync_state_type st_nxt;

  // Shift chain; first stage feeds only the second
  always_comb begin
    st_nxt        = st_r;
    st_nxt.s1     = pin_i;
    st_nxt.s2     = st_r.s1;
    st_nxt.s3     = st_r.s2;
    st_nxt.stable = (st_r.s2 == st_r.s3) ? st_r.s3 : st_r.stable;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, stable: RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.stable;

endmodule

// File: pll_clock_fanout_banks.sv
// Purpose: Digital model of a phase-locked clock driver with two output banks
// Assumes: Board wires one bank output back to the feedback pin
// Notes:   Loop runs at 1/16 scale; outputs are tri-state via out_drive_n_o
`timescale 1ns/1ns

// What this block does
// - Lock is reported only after the settling interval has passed.
// - Oscillator speed is trimmed until feedback edges meet reference edges.
// - Enable low drives all six outputs; enable high floats them.
// - Enable falling restarts the settling interval before lock.
// - Select sets bank one's ratio to the reference.
// - Test low runs through the loop; test high bypasses it.
// - Bank one carries oscillator over two or over four, per select.
// - Bank two always carries oscillator over two.
// - Every output has a 50% duty cycle.
// - Oscillator stays within its range; its divided products are 50% duty.
// - Fed-back one-times output, select high halves bank one.
// - Fed-back one-times output, select leaves bank two at the same rate.
module pll_clock_fanout_banks #(
  parameter logic [15:0] STAB_CYCLES = 16'(fanout_pkg::STAB_CYC)
) (
  input  wire logic               clk_i,
  input  wire logic               nrst_i,
  input  wire logic               reference_clock_in_i,
  input  wire logic               feedback_clock_in_i,
  input  wire logic               out_enable_n_i,
  input  wire logic               bank_select_i,
  input  wire logic               test_bypass_i,
  output fanout_pkg::bank_clk_type bank_one_clocks_o,
  output fanout_pkg::bank_clk_type bank_two_clocks_o,
  output logic                    out_drive_n_o,
  output logic                    locked_o
);
  import fanout_pkg::*;

  logic             ref_slow;
  logic [PIN_N-1:0] raw;
  logic [PIN_N-1:0] lvl;
  pin_lvl_type      pin;
  core_state_type   st_r;
  core_state_type   st_nxt;
  logic             ref_evt;
  logic             fb_evt;
  logic [ACC_W:0]   sum;
  logic             tick;
  logic             restart;

  // Reference is slowed in its own domain before it crosses
  ref_prescale u_pre (
    .reference_clock_in_i (reference_clock_in_i),
    .nrst_i               (nrst_i),
    .ref_slow_o           (ref_slow)
  );

  // Every asynchronous pin passes a three-stage synchroniser
  assign raw = {ref_slow, feedback_clock_in_i, out_enable_n_i, bank_select_i, test_bypass_i};

  for (genvar i = 0; i < PIN_N; i++) begin : g_sync
    pin_sync #(
      .RST_VAL (PIN_RST[i])
    ) u_sync (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .pin_i   (raw[i]),
      .level_o (lvl[i])
    );
  end

  assign pin = pin_lvl_type'(lvl);

  // Rising edges of prescaled reference and of feedback
  assign ref_evt = pin.ref_tog & ~st_r.ref_prev;
  assign fb_evt  = pin.fb & ~st_r.fb_prev;

  // Phase accumulator; its carry is one oscillator period
  assign sum  = {1'b0, st_r.acc} + {1'b0, st_r.inc};
  assign tick = pin.test ? ref_evt : sum[ACC_W];

  // Anything that disturbs reference or feedback restarts settling
  assign restart = (pin.sel != st_r.sel_prev)
                 | (st_r.oe_prev & ~pin.oe_n)
                 | (st_r.test_prev & ~pin.test)
                 | (ref_evt & ~st_r.ref_ok);

  // Next state of the whole loop
  always_comb begin
    st_nxt           = st_r;
    st_nxt.ref_prev  = pin.ref_tog;
    st_nxt.fb_prev   = pin.fb;
    st_nxt.sel_prev  = pin.sel;
    st_nxt.oe_prev   = pin.oe_n;
    st_nxt.test_prev = pin.test;
    st_nxt.acc       = sum[ACC_W-1:0];

    // Divider chain gives over-two and over-four, both 50% duty
    if (tick) begin
      st_nxt.div = st_r.div + 2'b01;
    end

    // Bang-bang phase detector trims the increment
    if (pin.test) begin
      st_nxt.ref_lead = 1'b0;
      st_nxt.fb_lead  = 1'b0;
    end else if (ref_evt && fb_evt) begin
      st_nxt.ref_lead = 1'b0;
      st_nxt.fb_lead  = 1'b0;
    end else if (ref_evt) begin
      if (st_r.fb_lead) begin
        st_nxt.fb_lead = 1'b0;
        st_nxt.inc = (st_r.inc < INC_MIN + INC_STEP) ? INC_MIN : st_r.inc - INC_STEP;
      end else begin
        st_nxt.ref_lead = 1'b1;
      end
    end else if (fb_evt) begin
      if (st_r.ref_lead) begin
        st_nxt.ref_lead = 1'b0;
        st_nxt.inc = (st_r.inc > INC_MAX - INC_STEP) ? INC_MAX : st_r.inc + INC_STEP;
      end else begin
        st_nxt.fb_lead = 1'b1;
      end
    end

    // Reference presence watchdog
    if (ref_evt) begin
      st_nxt.gap    = '0;
      st_nxt.ref_ok = 1'b1;
    end else if (st_r.gap != GAP_MAX) begin
      st_nxt.gap = st_r.gap + 9'h001;
    end else begin
      st_nxt.ref_ok = 1'b0;
    end

    // Settling timer and lock flag
    if (restart) begin
      st_nxt.stab = STAB_CYCLES;
    end else if (st_r.stab != '0) begin
      st_nxt.stab = st_r.stab - 16'h0001;
    end
    st_nxt.locked = (st_r.stab == '0) & ~restart & st_r.ref_ok & ~pin.test & ~pin.oe_n;

    // Bank routing by select; bank two fixed at over-two
    st_nxt.bank1   = {3{pin.sel ? st_nxt.div[1] : st_nxt.div[0]}};
    st_nxt.bank2   = {3{st_nxt.div[0]}};
    st_nxt.drive_n = pin.oe_n;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r      <= CORE_RST;
      st_r.stab <= STAB_CYCLES;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign bank_one_clocks_o = st_r.bank1;
  assign bank_two_clocks_o = st_r.bank2;
  assign out_drive_n_o     = st_r.drive_n;
  assign locked_o          = st_r.locked;

  // Helper: cycles since the last restart, saturating
  logic [16:0] since_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      since_r <= '0;
    end else if (restart) begin
      since_r <= '0;
    end else if (since_r != 17'h1_FFFF) begin
      since_r <= since_r + 17'h0_0001;
    end
  end

  // Helper: cycles since the last oscillator tick; held at zero in bypass
  // A long gap here means the increment fell below the slowest oscillator
  logic [5:0] tick_gap_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_gap_r <= '0;
    end else if (tick || pin.test) begin
      tick_gap_r <= '0;
    end else if (tick_gap_r != 6'h3F) begin
      tick_gap_r <= tick_gap_r + 6'h01;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // Drivers follow the synchronised enable one cycle later
  chk_drive_follow_oe: assert property (
    ##1 out_drive_n_o == $past(pin.oe_n)
  ) else $error("output drive does not follow enable");

  // Bank two moves only on a divider tick
  chk_bank_two_tick: assert property (
    $changed(bank_two_clocks_o) |-> $past(tick)
  ) else $error("bank two changed without a tick");

  // With select high, bank one moves only as bank two falls
  chk_bank_one_quarter: assert property (
    ($past(pin.sel) && $past(pin.sel, 2) && $changed(bank_one_clocks_o)) |-> $fell(bank_two_clocks_o[0])
  ) else $error("bank one is not at half the rate of bank two");

  // With select low, both banks carry the same clock
  chk_sel_low_equal: assert property (
    ##1 !$past(pin.sel) |-> bank_one_clocks_o == bank_two_clocks_o
  ) else $error("banks differ with select low");

  // Lock rises exactly one settling interval plus one cycle after restart
  chk_lock_interval: assert property (
    $rose(locked_o) |-> since_r == 17'(STAB_CYCLES) + 17'h0_0001
  ) else $error("lock rose at the wrong time");

  // Enable fall forces lock low for the following cycles
  chk_oe_fall_relock: assert property (
    $fell(pin.oe_n) |=> !locked_o [*8]
  ) else $error("lock held across enable fall");

  // Increment never leaves the oscillator range
  chk_inc_range: assert property (
    st_r.inc >= INC_MIN && st_r.inc <= INC_MAX
  ) else $error("oscillator increment out of range");

  // Late feedback speeds the oscillator by one step
  chk_fb_late_speed: assert property (
    (fb_evt && !ref_evt && st_r.ref_lead && !pin.test && st_r.inc <= INC_MAX - INC_STEP)
      |=> st_r.inc == $past(st_r.inc) + INC_STEP
  ) else $error("late feedback did not raise the increment");

  // In bypass, dividers step only on reference edges
  chk_bypass_tick: assert property (
    ($past(pin.test) && $changed(st_r.div)) |-> $past(ref_evt)
  ) else $error("divider stepped without reference in bypass");

  // Lock never stands inside the settling interval
  chk_lock_settled: assert property (
    locked_o |-> since_r > 17'(STAB_CYCLES)
  ) else $error("lock reported before settling");

  // Lock is only reported while the outputs drive
  chk_lock_drive: assert property (
    locked_o |-> !out_drive_n_o
  ) else $error("lock reported while outputs float");

  // Lock is never reported in bypass
  chk_lock_no_bypass: assert property (
    locked_o |-> !$past(pin.test)
  ) else $error("lock reported in bypass");

  // Bypass freezes the phase detector
  chk_bypass_frozen: assert property (
    pin.test |=> !st_r.ref_lead && !st_r.fb_lead
  ) else $error("phase detector active in bypass");

  // Divider only counts up by one, so each output spends equal ticks high and low
  chk_div_count_up: assert property (
    $changed(st_r.div) |-> st_r.div == $past(st_r.div) + 2'b01
  ) else $error("divider skipped a step");

  // Every restart reloads the full settling interval
  chk_timer_reload: assert property (
    restart |=> st_r.stab == STAB_CYCLES
  ) else $error("settling timer not reloaded");

  // Missing reference drops lock at once
  chk_ref_loss_unlock: assert property (
    !st_r.ref_ok |=> !locked_o
  ) else $error("lock held without reference");

  // Select change forces lock low for the following cycles
  chk_sel_change_unlock: assert property (
    $changed(pin.sel) |=> !locked_o [*8]
  ) else $error("lock held across select change");

  // Leaving bypass forces lock low for the following cycles
  chk_test_fall_unlock: assert property (
    $fell(pin.test) |=> !locked_o [*8]
  ) else $error("lock held across bypass exit");

  // Oscillator never runs slower than one period at the lowest increment
  chk_tick_period: assert property (
    tick_gap_r < 6'(((2 ** ACC_W) + int'(INC_MIN) - 1) / int'(INC_MIN))
  ) else $error("oscillator slower than its range");

  // Coincident edges mean zero phase error: the increment holds
  chk_in_phase_hold: assert property (
    (ref_evt && fb_evt && !pin.test) |=> st_r.inc == $past(st_r.inc)
  ) else $error("increment moved on zero phase error");

  // Main scenarios: lock, select high, bypass, floating, late feedback
  cov_lock: cover property ($rose(locked_o));
  cov_sel_high_lock: cover property (locked_o && pin.sel);
  cov_bypass: cover property (pin.test && tick);
  cov_float: cover property (out_drive_n_o && !locked_o);
  cov_fb_late: cover property (fb_evt && st_r.ref_lead && !pin.test);

endmodule

// File: board_clock_source.sv
// Purpose: Board-side model: reference clock source and feedback wiring
// Assumes: Bank two output 0 is the one wired back to the feedback pin
// Notes:   Reference parks low while stopped; a floating feedback line flips
`timescale 1ns/1ns
module board_clock_source (
  input  wire logic run_i,
  input  wire logic fb_src_i,
  input  wire logic drive_n_i,
  output logic      reference_clock_in_o,
  output logic      feedback_clock_in_o
);
  logic fb_last = 1'b0;

  // Steady 6 ns reference of fixed phase, held low while stopped
  initial begin
    reference_clock_in_o = 1'b0;
    // Rising edges land on odd ns, never on a system clock edge
    #2;
    forever begin
      #3;
      reference_clock_in_o = run_i ? ~reference_clock_in_o : 1'b0;
    end
  end

  // Remember the last level the output actually drove
  always @(fb_src_i or drive_n_i) begin
    if (!drive_n_i) begin
      fb_last = fb_src_i;
    end
  end

  // Exactly one output wired to feedback; no pull, so a float shows the inverse
  assign feedback_clock_in_o = drive_n_i ? ~fb_last : fb_src_i;
endmodule

// File: tb_top.sv
// Purpose: Self-checking bench for the two-bank clock fan-out block
// Assumes: Settling interval shortened to 32 cycles; reference period 6 ns
// Notes:   Rates are judged by counting output toggles over fixed windows
`timescale 1ns/1ns
module tb_top;
  import fanout_pkg::*;
  logic         clk_i;
  logic         nrst_i;
  logic         ref_run;
  logic         out_enable_n_i;
  logic         bank_select_i;
  logic         test_bypass_i;
  logic         reference_clock_in_i;
  logic         feedback_clock_in_i;
  bank_clk_type bank_one_clocks_o;
  bank_clk_type bank_two_clocks_o;
  logic         out_drive_n_o;
  logic         locked_o;
  int           errors;
  int           total_checks;
  int           cycles;
  int           t1, t2, h2, minrun, unequal;

  pll_clock_fanout_banks #(.STAB_CYCLES(16'h0020)) u_pll_clock_fanout_banks (
    .clk_i(clk_i), .nrst_i(nrst_i), .reference_clock_in_i(reference_clock_in_i),
    .feedback_clock_in_i(feedback_clock_in_i), .out_enable_n_i(out_enable_n_i),
    .bank_select_i(bank_select_i), .test_bypass_i(test_bypass_i),
    .bank_one_clocks_o(bank_one_clocks_o), .bank_two_clocks_o(bank_two_clocks_o),
    .out_drive_n_o(out_drive_n_o), .locked_o(locked_o));

  board_clock_source u_board_clock_source (
    .run_i(ref_run), .fb_src_i(bank_two_clocks_o[0]), .drive_n_i(out_drive_n_o),
    .reference_clock_in_o(reference_clock_in_i), .feedback_clock_in_o(feedback_clock_in_i));

  // System clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Cut a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 10000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic near(input string name, input int exp, input int got, input int tol);
    total_checks++;
    if (got < exp - tol || got > exp + tol) begin
      errors++;
      $display("unexpected %s: expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Count toggles, high time and shortest half period over n cycles
  task automatic measure(input int n);
    logic p1, p2;
    int   run;
    t1 = 0;
    t2 = 0;
    h2 = 0;
    unequal = 0;
    minrun = 9999;
    run = -1000;
    // Sample on the falling edge, clear of the edge that launches the outputs
    @(negedge clk_i);
    p1 = bank_one_clocks_o[0];
    p2 = bank_two_clocks_o[0];
    repeat (n) begin
      @(negedge clk_i);
      if (bank_one_clocks_o[0] !== p1) t1++;
      if (bank_two_clocks_o[0] !== p2) begin
        t2++;
        if (run >= 0 && run + 1 < minrun) minrun = run + 1;
        run = -1;
      end
      run++;
      if (bank_two_clocks_o[0] === 1'b1) h2++;
      if (bank_one_clocks_o !== {3{bank_one_clocks_o[0]}}) unequal++;
      if (bank_two_clocks_o !== {3{bank_two_clocks_o[0]}}) unequal++;
      p1 = bank_one_clocks_o[0];
      p2 = bank_two_clocks_o[0];
    end
  endtask

  task automatic enable_and_lock();
    out_enable_n_i = 1'b0;
    wait_cyc(8);
    check("drive_n", 0, out_drive_n_o);
    wait_cyc(12);
    check("locked early", 0, locked_o);
    wait_cyc(40);
    check("locked", 1, locked_o);
  endtask

  task automatic ratio(input logic sel);
    bank_select_i = sel;
    wait_cyc(12);
    check("locked after select", 0, locked_o);
    wait_cyc(48);
    check("locked after select", 1, locked_o);
    measure(400);
    check("bank bits equal", 0, unequal);
    near("bank one toggles", sel ? t2 / 2 : t2, t1, 2);
    near("bank two high", 200, h2, 12);
    check("half period in range", 1, minrun >= 9 && minrun <= 21);
  endtask

  task automatic bypass();
    test_bypass_i = 1'b1;
    wait_cyc(8);
    check("locked in bypass", 0, locked_o);
    measure(1200);
    near("bypass bank two toggles", 100, t2, 2);
    near("bypass bank one toggles", 50, t1, 2);
    test_bypass_i = 1'b0;
    wait_cyc(60);
    check("locked after bypass", 1, locked_o);
  endtask

  task automatic float_and_loss();
    out_enable_n_i = 1'b1;
    wait_cyc(8);
    check("drive_n floating", 1, out_drive_n_o);
    check("locked floating", 0, locked_o);
    enable_and_lock();
    ref_run = 1'b0;
    wait_cyc(320);
    check("locked without reference", 0, locked_o);
    ref_run = 1'b1;
    wait_cyc(120);
    check("locked reference back", 1, locked_o);
  endtask

  task automatic report_and_stop();
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence; reset, lock, both select ratios, bypass, then floating and reference loss
  initial begin
    errors = 0;
    total_checks = 0;
    cycles = 0;
    nrst_i = 1'b0;
    ref_run = 1'b1;
    out_enable_n_i = 1'b1;
    bank_select_i = 1'b0;
    test_bypass_i = 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check("reset drive_n", 1, out_drive_n_o);
    check("reset locked", 0, locked_o);
    check("reset banks", 0, {bank_one_clocks_o, bank_two_clocks_o});
    nrst_i = 1'b1;
    wait_cyc(40);
    check("locked while floating", 0, locked_o);
    enable_and_lock();
    ratio(1'b1);
    ratio(1'b0);
    bank_select_i = 1'b1;
    bypass();
    float_and_loss();
    report_and_stop();
  end
endmodule
